//--- src/host_port_defs.vh
// constants shared by the host bus port and its register store
// assumes a single 100 MHz clock domain
`ifndef HOST_PORT_DEFS_VH
`define HOST_PORT_DEFS_VH

// ****************************************
// widths
// ****************************************
`define ADDR_W          7
`define DATA_W          8
`define REG_DEPTH       128
`define RST_CNT_W       17

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS   10
`define RESET_HOLD_US   500
`define NS_PER_US       1000

// ****************************************
// interrupt output styles
// ****************************************
`define IRQ_PP_HIGH     2'h0
`define IRQ_PP_LOW      2'h1
`define IRQ_OPEN_DRAIN  2'h2

// ****************************************
// bus strobe styles and reset values
// ****************************************
`define STYLE_SEPARATE  1'b0
`define STYLE_DATA_STB  1'b1
`define RW_READ         1'b1
`define ZERO_ADDR       7'h00
`define ZERO_DATA       8'h00

`endif

//--- src/reg_store.v
// small register store behind the host port, one write and one read port
// assumes synchronous write and read addresses; read data is registered
`timescale 1ns/100ps
`include "host_port_defs.vh"

module reg_store (
  input  wire                 i_clk,
  input  wire                 i_rst,
  input  wire                 i_wr_en,
  input  wire [`ADDR_W-1:0]   i_wr_addr,
  input  wire [`DATA_W-1:0]   i_wr_data,
  input  wire [`ADDR_W-1:0]   i_rd_addr,
  output reg  [`DATA_W-1:0]   o_rd_data
);

  reg [`DATA_W-1:0] mem [0:`REG_DEPTH-1];

  // ****************************************
  // write port
  // ****************************************
  always @(posedge i_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  // ****************************************
  // registered read port
  // ****************************************
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= `ZERO_DATA;
    end else begin
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule // reg_store

//--- src/host_bus_interface_port.v
// parallel 8-bit host processor port: mux/demux address, two strobe styles,
// programmable interrupt request pin, reset hold and reset indication
// assumes all pin inputs are already synchronous to i_clk
`timescale 1ns/100ps
`include "host_port_defs.vh"

module host_bus_interface_port #(
  parameter RESET_HOLD_CYCLES = (`RESET_HOLD_US * `NS_PER_US) / `CLK_PERIOD_NS
) (
  input  wire                 i_clk,
  input  wire                 i_rst,
  input  wire                 i_cs_n,
  input  wire                 i_wr_n_rw,
  input  wire                 i_transfer_strobe_n,
  input  wire                 i_ale,
  input  wire                 i_bus_style,
  input  wire [`ADDR_W-1:0]   i_addr,
  input  wire [`DATA_W-1:0]   i_data,
  output wire [`DATA_W-1:0]   o_data,
  output wire                 o_data_oe,
  input  wire [1:0]           i_irq_style,
  input  wire                 i_irq_pending,
  output reg                  o_host_interrupt_out,
  output reg                  o_host_interrupt_oe,
  input  wire                 i_host_interrupt_acknowledge_n,
  output reg                  o_irq_ack,
  output reg                  o_reset_in_progress_out,
  output reg                  o_reg_wr,
  output reg  [`ADDR_W-1:0]   o_reg_addr,
  output reg  [`DATA_W-1:0]   o_reg_wdata
);

  // ****************************************
  // states, one-hot
  // ****************************************
  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_READ  = 3'h2;
  localparam [2:0] ST_WRITE = 3'h4;

  localparam integer          HOLD_LAST_I = RESET_HOLD_CYCLES - 1;
  localparam [`RST_CNT_W-1:0] HOLD_LAST   = HOLD_LAST_I[`RST_CNT_W-1:0];

  reg  [2:0]           state_r;
  reg  [2:0]           state_nxt;
  reg  [`ADDR_W-1:0]   latch_addr_r;
  reg  [`ADDR_W-1:0]   access_addr_r;
  reg                  oe_r;
  reg  [`RST_CNT_W-1:0] hold_cnt_r;
  reg                  ack_seen_r;

  wire                 selected;
  wire                 rd_req;
  wire                 wr_req;
  wire                 mux_mode;
  wire [`ADDR_W-1:0]   eff_addr;
  wire [`ADDR_W-1:0]   mem_rd_addr;
  wire                 mem_wr;

  // ****************************************
  // request decode
  // ****************************************
  assign selected = !i_cs_n && !i_transfer_strobe_n && !o_reset_in_progress_out;

  // separate style: low write strobe is a write, strobe pin is the read
  // data-strobe style: direction input says read or write
  assign rd_req = (i_bus_style == `STYLE_SEPARATE) ? selected
                : (selected && (i_wr_n_rw == `RW_READ));
  assign wr_req = (i_bus_style == `STYLE_SEPARATE)
                ? (!i_cs_n && !i_wr_n_rw && !o_reset_in_progress_out)
                : (selected && (i_wr_n_rw != `RW_READ));

  // ****************************************
  // address latch
  // ****************************************
  assign mux_mode = !i_ale;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      latch_addr_r <= `ZERO_ADDR;
    end else if (i_ale) begin
      latch_addr_r <= i_addr;
    end
  end

  // while the latch strobe is high the latch is open, after its fall
  // the held value stands; demux mode always uses the live address
  assign eff_addr = mux_mode ? latch_addr_r : i_addr;

  // ****************************************
  // access state machine
  // ****************************************
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (rd_req) begin
          state_nxt = ST_READ;
        end else if (wr_req) begin
          state_nxt = ST_WRITE;
        end
      end
      ST_READ: begin
        if (!rd_req) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (!wr_req) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r       <= ST_IDLE;
      access_addr_r <= `ZERO_ADDR;
      oe_r          <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE) begin
        access_addr_r <= eff_addr;
      end
      // the pin is driven only for the cycles of a selected read
      oe_r <= rd_req && (state_nxt == ST_READ);
    end
  end

  // ****************************************
  // register store and core-side write strobe
  // ****************************************
  assign mem_wr      = (state_r == ST_IDLE) && (state_nxt == ST_WRITE);
  assign mem_rd_addr = (state_r == ST_IDLE) ? eff_addr : access_addr_r;

  reg_store u_store (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_wr_en   (mem_wr),
    .i_wr_addr (eff_addr),
    .i_wr_data (i_data),
    .i_rd_addr (mem_rd_addr),
    .o_rd_data (o_data)
  );

  assign o_data_oe = oe_r && rd_req;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_wr    <= 1'b0;
      o_reg_addr  <= `ZERO_ADDR;
      o_reg_wdata <= `ZERO_DATA;
    end else begin
      o_reg_wr <= mem_wr;
      if (mem_wr) begin
        o_reg_addr  <= eff_addr;
        o_reg_wdata <= i_data;
      end
    end
  end

  // ****************************************
  // reset hold and indication
  // ****************************************
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      hold_cnt_r              <= {`RST_CNT_W{1'b0}};
      o_reset_in_progress_out <= 1'b1;
    end else if (o_reset_in_progress_out) begin
      if (hold_cnt_r == HOLD_LAST) begin
        o_reset_in_progress_out <= 1'b0;
      end else begin
        hold_cnt_r <= hold_cnt_r + 1'b1;
      end
    end
  end

  // ****************************************
  // interrupt pin and acknowledge
  // ****************************************
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_host_interrupt_out <= 1'b0;
      o_host_interrupt_oe  <= 1'b0;
      ack_seen_r           <= 1'b0;
      o_irq_ack            <= 1'b0;
    end else begin
      ack_seen_r <= !i_host_interrupt_acknowledge_n;
      o_irq_ack  <= !i_host_interrupt_acknowledge_n && !ack_seen_r;
      if (o_reset_in_progress_out) begin
        o_host_interrupt_out <= 1'b0;
        o_host_interrupt_oe  <= 1'b0;
      end else begin
        case (i_irq_style)
          `IRQ_PP_HIGH: begin
            o_host_interrupt_out <= i_irq_pending;
            o_host_interrupt_oe  <= 1'b1;
          end
          `IRQ_PP_LOW: begin
            o_host_interrupt_out <= !i_irq_pending;
            o_host_interrupt_oe  <= 1'b1;
          end
          `IRQ_OPEN_DRAIN: begin
            o_host_interrupt_out <= 1'b0;
            o_host_interrupt_oe  <= i_irq_pending;
          end
          default: begin
            o_host_interrupt_out <= 1'b0;
            o_host_interrupt_oe  <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // host_bus_interface_port

//--- verif/host_bus_interface_port_assertions.sv
// assertion checker for the host bus port, bound to its top module
// assumes the reset hold parameter is handed on by the bind
`timescale 1ns/100ps
module hbp_checker #(parameter RESET_HOLD_CYCLES = 20) (
  input wire       i_clk,
  input wire       i_rst,
  input wire       i_cs_n,
  input wire       i_wr_n_rw,
  input wire       i_transfer_strobe_n,
  input wire       i_bus_style,
  input wire [7:0] i_data,
  input wire [1:0] i_irq_style,
  input wire       i_irq_pending,
  input wire       o_data_oe,
  input wire       o_host_interrupt_out,
  input wire       o_host_interrupt_oe,
  input wire       o_reset_in_progress_out,
  input wire       o_reg_wr,
  input wire [7:0] o_reg_wdata,
  input wire       i_host_interrupt_acknowledge_n,
  input wire       o_irq_ack
);
  wire ind = o_reset_in_progress_out;
  wire rd_req = !i_cs_n && !i_transfer_strobe_n && (!i_bus_style || i_wr_n_rw);
  reg [15:0] cnt_r;
  // cycles since reset release, saturating past the hold
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst)
      cnt_r <= 16'h0000;
    else if (cnt_r <= RESET_HOLD_CYCLES)
      cnt_r <= cnt_r + 16'h0001;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  hold_count_a: assert property (ind == (cnt_r < RESET_HOLD_CYCLES))
    else $error("reset hold length wrong");
  oe_read_a: assert property (o_data_oe |-> rd_req && !ind)
    else $error("data driven outside a read");
  rd_answer_a: assert property (
    rd_req && !ind && $fell(i_transfer_strobe_n) ##1 rd_req |-> o_data_oe)
    else $error("read not answered");
  wr_taken_a: assert property (
    !i_cs_n && !ind && (i_bus_style ? $fell(i_transfer_strobe_n) && !i_wr_n_rw
    : $fell(i_wr_n_rw) && i_transfer_strobe_n) |=> o_reg_wr && o_reg_wdata == $past(i_data))
    else $error("write not taken");
  cs_ignore_a: assert property (i_cs_n |=> !o_reg_wr)
    else $error("write while not selected");
  irq_high_a: assert property (
    !ind && i_irq_style == 2'h0 |=> o_host_interrupt_oe
    && o_host_interrupt_out == $past(i_irq_pending))
    else $error("active high interrupt wrong");
  irq_low_a: assert property (
    !ind && i_irq_style == 2'h1 |=> o_host_interrupt_oe
    && o_host_interrupt_out != $past(i_irq_pending))
    else $error("active low interrupt wrong");
  irq_od_a: assert property (
    !ind && i_irq_style == 2'h2 |=> !o_host_interrupt_out
    && o_host_interrupt_oe == $past(i_irq_pending))
    else $error("open drain interrupt wrong");
  ack_pulse_a: assert property ($fell(i_host_interrupt_acknowledge_n) |=> o_irq_ack)
    else $error("acknowledge not pulsed");
  ack_single_a: assert property (o_irq_ack |=> !o_irq_ack)
    else $error("acknowledge pulse too long");
endmodule // hbp_checker

bind host_bus_interface_port hbp_checker #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)) i_hbp_checker (
  .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_wr_n_rw(i_wr_n_rw),
  .i_transfer_strobe_n(i_transfer_strobe_n), .i_bus_style(i_bus_style), .i_data(i_data),
  .i_irq_style(i_irq_style), .i_irq_pending(i_irq_pending), .o_data_oe(o_data_oe),
  .o_host_interrupt_out(o_host_interrupt_out), .o_host_interrupt_oe(o_host_interrupt_oe),
  .o_reset_in_progress_out(o_reset_in_progress_out), .o_reg_wr(o_reg_wr),
  .o_reg_wdata(o_reg_wdata), .i_host_interrupt_acknowledge_n(i_host_interrupt_acknowledge_n),
  .o_irq_ack(o_irq_ack));

//--- verif/host_side_model.sv
// host side of the port: resolves the shared data bus and the interrupt wire
// assumes a pull-up on the interrupt wire and none on the data bus
`timescale 1ns/100ps
module host_side_model (
  input  wire       i_clk,
  input  wire [7:0] i_dev_data,
  input  wire       i_dev_oe,
  input  wire [7:0] i_host_data,
  input  wire       i_host_oe,
  input  wire       i_irq_out,
  input  wire       i_irq_oe,
  output wire [7:0] o_bus,
  output wire       o_irq_line
);
  reg [7:0] last_r = 8'h00;
  // a released bus shows the inverse of its last level, never a held value
  assign o_bus = i_dev_oe ? i_dev_data : (i_host_oe ? i_host_data : ~last_r);
  assign o_irq_line = i_irq_oe ? i_irq_out : 1'b1;
  always @(posedge i_clk) begin
    last_r <= o_bus;
  end
endmodule // host_side_model

//--- verif/tb_top.sv
// self-checking bench for the host bus port and its host side model
// assumes a reset hold shortened to 20 cycles
`timescale 1ns/100ps
module tb_top;
  reg clk = 1'b0, rst = 1'b1, cs_n = 1'b1, wr = 1'b1, stb = 1'b1, ale = 1'b1;
  reg sty = 1'b0, mx = 1'b0, hoe = 1'b0, irp = 1'b0, ack_n = 1'b1;
  reg [1:0] irs = 2'h0;
  reg [6:0] adr = 7'h00;
  reg [7:0] hd = 8'h00, got;
  integer err_total = 0, comparisons = 0, cyc = 0, n;
  wire [7:0] bus, od, wd;
  wire [6:0] ra;
  wire oe, io, ie, line, ind, ack;
  host_bus_interface_port #(.RESET_HOLD_CYCLES(20)) i_host_bus_interface_port (
    .i_clk(clk), .i_rst(rst), .i_cs_n(cs_n), .i_wr_n_rw(wr), .i_transfer_strobe_n(stb),
    .i_ale(ale), .i_bus_style(sty), .i_addr(mx ? bus[6:0] : adr), .i_data(bus),
    .o_data(od), .o_data_oe(oe), .i_irq_style(irs), .i_irq_pending(irp),
    .o_host_interrupt_out(io), .o_host_interrupt_oe(ie),
    .i_host_interrupt_acknowledge_n(ack_n), .o_irq_ack(ack), .o_reset_in_progress_out(ind),
    .o_reg_wr(), .o_reg_addr(ra), .o_reg_wdata(wd));
  host_side_model i_host_side_model (.i_clk(clk), .i_dev_data(od), .i_dev_oe(oe),
    .i_host_data(hd), .i_host_oe(hoe), .i_irq_out(io), .i_irq_oe(ie), .o_bus(bus),
    .o_irq_line(line));
  initial forever #5 clk = !clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_total = err_total + 1;
      print_verdict;
    end
  end
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // one access: address phase, then strobe held three cycles
  task acc(input s, input m, input w, input c, input [6:0] a, input [7:0] d);
    begin
      @(posedge clk) #1;
      sty = s;
      mx = m;
      cs_n = c;
      adr = a;
      hd = m ? {1'b0, a} : d;
      hoe = m | w;
      @(posedge clk) #1;
      ale = !m;
      hd = d;
      hoe = w;
      if (s)
        wr = !w;
      if (s | !w)
        stb = 1'b0;
      else
        wr = 1'b0;
      got = 8'h00;
      repeat (3) begin
        @(posedge clk) #1;
        if (oe !== 1'b0)
          got = bus;
      end
      stb = 1'b1;
      wr = 1'b1;
      cs_n = 1'b1;
      hoe = 1'b0;
      ale = 1'b1;
    end
  endtask
  task t_rst;
    begin
      rst = 1'b1;
      repeat (20) @(posedge clk);
      #1 chk(ind, 1'b1);
      rst = 1'b0;
      n = 0;
      while (ind === 1'b1 && n < 99) begin
        @(posedge clk) #1;
        n = n + 1;
      end
      chk(n[7:0], 8'h14);
    end
  endtask
  task t_bus;
    integer i;
    reg [6:0] a;
    reg [7:0] d;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        a = {i[1:0], 5'h1f};
        d = 8'ha5 ^ i[7:0];
        acc(i[0], i[1], 1'b1, 1'b0, a, d);
        chk({1'b0, ra}, {1'b0, a});
        chk(wd, d);
        acc(i[0], i[1], 1'b0, 1'b0, a, 8'h00);
        chk(got, d);
      end
      acc(1'b0, 1'b0, 1'b1, 1'b1, 7'h1f, 8'h5a);
      chk(wd, 8'ha6);
      acc(1'b0, 1'b0, 1'b0, 1'b1, 7'h1f, 8'h00);
      chk(got, 8'h00);
      acc(1'b1, 1'b0, 1'b0, 1'b0, 7'h1f, 8'h00);
      chk(got, 8'ha5);
    end
  endtask
  task t_irq;
    integer s, p;
    begin
      for (s = 0; s < 4; s = s + 1)
        for (p = 0; p < 2; p = p + 1) begin
          irs = s[1:0];
          irp = p[0];
          repeat (2) @(posedge clk);
          #1 chk({ie, line}, s == 3 ? 2'h1 : s == 2 ? {p[0], !p[0]} : {1'b1, p[0] ^ s[0]});
        end
      ack_n = 1'b0;
      @(posedge clk) #1 chk(ack, 1'b1);
      @(posedge clk) #1 chk(ack, 1'b0);
      ack_n = 1'b1;
    end
  endtask
  task print_verdict;
    begin
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    t_rst;
    t_bus;
    t_irq;
    t_rst;
    t_irq;
    print_verdict;
  end
endmodule // tb_top
